// ===== hw/ulsf_break_detect.sv
module ulsf_break_detect (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // receive line
  input  wire logic                          rxIn,
  input  wire logic                          bitTick,
  input  wire logic [ulsf_pkg::BITCNT_W-1:0] frameBits,
  // detection
  output logic                               breakPulse
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ulsf_pkg::BITCNT_W-1:0] cnt;
    logic                          done;
    logic                          pulse;
  } ulsf_brk_t;

  ulsf_brk_t                     s;
  ulsf_brk_t                     n;
  logic [ulsf_pkg::BITCNT_W-1:0] cntInc;

  assign cntInc     = s.cnt + 4'h1;
  assign breakPulse = s.pulse;

  // done latches until the line returns high, so a long break
  // yields a single character
  always_comb begin
    n = s;
    n.pulse = 1'h0;
    if (rxIn) begin
      n.cnt  = '0;
      n.done = 1'h0;
    end else if (bitTick && !s.done) begin
      n.cnt = cntInc;
      if (cntInc == frameBits) begin
        n.pulse = 1'h1;
        n.done  = 1'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  a_break_once: assert property (
    @(posedge mclk) disable iff (reset)
    breakPulse ##1 !rxIn |-> !breakPulse)
    else $error("second break pulse within one break");

  a_break_low: assert property (
    @(posedge mclk) disable iff (reset)
    breakPulse |-> $past(!rxIn) && $past(bitTick))
    else $error("break pulse without low line");
endmodule

// ===== hw/ulsf_line_status.sv
module ulsf_line_status (
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           reset,
  // axi4-lite write address and data
  input  wire logic [ulsf_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]                     awprot,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [ulsf_pkg::DATA_W-1:0]    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  // axi4-lite write response
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  // axi4-lite read
  input  wire logic [ulsf_pkg::ADDR_W-1:0]    araddr,
  input  wire logic [2:0]                     arprot,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic [ulsf_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  // receiver
  input  wire logic                           rxIn,
  input  wire logic                           bitTick,
  input  wire logic [ulsf_pkg::BITCNT_W-1:0]  frameBits,
  input  wire logic                           rxCharDone,
  input  wire logic                           rxParityBad,
  input  wire logic                           rxStopBad,
  // receive fifo
  input  wire logic                           rxFifoFull,
  input  wire logic                           rxEmpty,
  input  wire logic [ulsf_pkg::HF_W-1:0]      rxHeadFlags,
  output logic                                rxPush,
  output logic [ulsf_pkg::HF_W-1:0]           rxPushFlags,
  // transmitter
  input  wire logic                           txWrite,
  input  wire logic                           txMove,
  input  wire logic                           txFifoEmpty,
  input  wire logic                           txShiftEmpty,
  // interrupts
  output logic                                holdIrq,
  output logic                                irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ulsf_pkg::ulsf_wr_t            wr;
    logic                          awHeld;
    logic [ulsf_pkg::ADDR_W-1:0]   awAddr;
    logic                          wHeld;
    logic [ulsf_pkg::DATA_W-1:0]   wData;
    logic [3:0]                    wStrb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [ulsf_pkg::DATA_W-1:0]   rdata;
    logic [1:0]                    rresp;
    logic [7:0]                    ls;
    logic [ulsf_pkg::CTRL_W-1:0]   ctrl;
    logic [ulsf_pkg::INT_W-1:0]    intStat;
    logic [ulsf_pkg::INT_W-1:0]    intMask;
    logic                          irq;
    logic                          holdIrq;
    logic                          rxPush;
    logic [ulsf_pkg::HF_W-1:0]     rxPushFlags;
    logic                          txEmptyPrev;
  } ulsf_state_t;

  localparam ulsf_state_t RESET_ST = '{
    wr:          ulsf_pkg::WR_COLLECT,
    awready:     1'h1,
    wready:      1'h1,
    arready:     1'h1,
    ls:          ulsf_pkg::LS_RESET,
    ctrl:        ulsf_pkg::CTRL_RESET,
    intStat:     ulsf_pkg::INT_RESET,
    intMask:     ulsf_pkg::INT_RESET,
    txEmptyPrev: 1'h1,
    default:     '0
  };

  ulsf_state_t                s;
  ulsf_state_t                n;
  logic [ulsf_pkg::INT_W-1:0] w1c;
  logic [ulsf_pkg::INT_W-1:0] ev;
  logic                       awHs;
  logic                       wHs;
  logic                       arHs;
  logic                       lsRead;
  logic                       fifoMode;
  logic                       brkPulse;
  logic                       charOk;
  logic                       overrun;
  logic                       pushNow;
  logic                       errPush;
  logic                       holdSet;

  // ----------------------------------------------------------------
  // break detection
  // ----------------------------------------------------------------
  ulsf_break_detect u_break (
    .mclk       (mclk),
    .reset      (reset),
    .rxIn       (rxIn),
    .bitTick    (bitTick),
    .frameBits  (frameBits),
    .breakPulse (brkPulse)
  );

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  assign awHs     = awvalid && s.awready;
  assign wHs      = wvalid && s.wready;
  assign arHs     = arvalid && s.arready;
  assign lsRead   = arHs && (araddr == ulsf_pkg::OFS_LINE_STATUS);
  assign fifoMode = s.ctrl[ulsf_pkg::CTRL_FIFO];
  // a break owns its character slot, so a coincident frame is dropped
  assign charOk   = rxCharDone && !rxFifoFull && !brkPulse;
  assign overrun  = rxCharDone && rxFifoFull;
  assign pushNow  = brkPulse || charOk;
  assign errPush  = brkPulse || (charOk && (rxParityBad || rxStopBad));
  // fifo mode reacts to the fifo draining, char mode to the move
  assign holdSet  = fifoMode ? (txFifoEmpty && !s.txEmptyPrev)
                             : txMove;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n   = s;
    w1c = '0;
    ev  = '0;
    // write channel: address and data taken in either order
    case (s.wr)
      ulsf_pkg::WR_COLLECT: begin
        if (awHs) begin
          n.awHeld = 1'h1;
          n.awAddr = awaddr;
        end
        if (wHs) begin
          n.wHeld = 1'h1;
          n.wData = wdata;
          n.wStrb = wstrb;
        end
        if (n.awHeld && n.wHeld) begin
          n.wr     = ulsf_pkg::WR_RESP;
          n.bvalid = 1'h1;
          n.bresp  = ulsf_pkg::RESP_OKAY;
          n.awHeld = 1'h0;
          n.wHeld  = 1'h0;
          case (n.awAddr)
            ulsf_pkg::OFS_LINE_STATUS: begin
              n.bresp = ulsf_pkg::RESP_OKAY;
            end
            ulsf_pkg::OFS_CONTROL: begin
              if (n.wStrb[0]) begin
                n.ctrl = n.wData[ulsf_pkg::CTRL_W-1:0];
              end
            end
            ulsf_pkg::OFS_INT_STATUS: begin
              if (n.wStrb[0]) begin
                w1c = n.wData[ulsf_pkg::INT_W-1:0];
              end
            end
            ulsf_pkg::OFS_INT_MASK: begin
              if (n.wStrb[0]) begin
                n.intMask = n.wData[ulsf_pkg::INT_W-1:0];
              end
            end
            default: begin
              n.bresp = ulsf_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      ulsf_pkg::WR_RESP: begin
        if (bready) begin
          n.bvalid = 1'h0;
          n.wr     = ulsf_pkg::WR_COLLECT;
        end
      end
      default: begin
        n.wr = ulsf_pkg::WR_COLLECT;
      end
    endcase
    n.awready = (n.wr == ulsf_pkg::WR_COLLECT) && !n.awHeld;
    n.wready  = (n.wr == ulsf_pkg::WR_COLLECT) && !n.wHeld;
    // read channel: one outstanding read
    if (arHs) begin
      n.arready = 1'h0;
      n.rvalid  = 1'h1;
      n.rresp   = ulsf_pkg::RESP_OKAY;
      case (araddr)
        ulsf_pkg::OFS_LINE_STATUS: n.rdata = ulsf_pkg::DATA_W'(s.ls);
        ulsf_pkg::OFS_CONTROL:     n.rdata = ulsf_pkg::DATA_W'(s.ctrl);
        ulsf_pkg::OFS_INT_STATUS:  n.rdata = ulsf_pkg::DATA_W'(s.intStat);
        ulsf_pkg::OFS_INT_MASK:    n.rdata = ulsf_pkg::DATA_W'(s.intMask);
        default: begin
          n.rdata = '0;
          n.rresp = ulsf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s.rvalid && rready) begin
      n.rvalid  = 1'h0;
      n.arready = 1'h1;
    end
    // receive fifo load
    n.rxPush      = pushNow;
    n.rxPushFlags = '0;
    if (brkPulse) begin
      n.rxPushFlags[ulsf_pkg::HF_BI] = 1'h1;
    end else begin
      n.rxPushFlags[ulsf_pkg::HF_FE] = rxStopBad;
      n.rxPushFlags[ulsf_pkg::HF_PE] = rxParityBad;
    end
    // receive side flags; set wins over the read clear
    n.ls[ulsf_pkg::LS_DR] = !rxEmpty;
    n.ls[ulsf_pkg::LS_OE] = overrun || (s.ls[ulsf_pkg::LS_OE] && !lsRead);
    if (fifoMode) begin
      n.ls[ulsf_pkg::LS_PE] = rxHeadFlags[ulsf_pkg::HF_PE] && !rxEmpty;
      n.ls[ulsf_pkg::LS_FE] = rxHeadFlags[ulsf_pkg::HF_FE] && !rxEmpty;
      n.ls[ulsf_pkg::LS_BI] = rxHeadFlags[ulsf_pkg::HF_BI] && !rxEmpty;
    end else begin
      n.ls[ulsf_pkg::LS_PE] = (charOk && rxParityBad) ||
                              (s.ls[ulsf_pkg::LS_PE] && !lsRead);
      n.ls[ulsf_pkg::LS_FE] = (charOk && rxStopBad) ||
                              (s.ls[ulsf_pkg::LS_FE] && !lsRead);
      n.ls[ulsf_pkg::LS_BI] = brkPulse ||
                              (s.ls[ulsf_pkg::LS_BI] && !lsRead);
    end
    n.ls[ulsf_pkg::LS_FERR] = errPush ||
                              (s.ls[ulsf_pkg::LS_FERR] && !lsRead);
    // transmit side flags
    n.ls[ulsf_pkg::LS_THRE] = holdSet ||
                              (s.ls[ulsf_pkg::LS_THRE] && !txWrite);
    // gated by holding empty so the two flags cannot disagree
    n.ls[ulsf_pkg::LS_TEMT] =
                              n.ls[ulsf_pkg::LS_THRE] &&
                              txShiftEmpty &&
                              txFifoEmpty;
    n.txEmptyPrev = txFifoEmpty;
    // interrupt status, mask and outputs
    ev[ulsf_pkg::INT_OVR]  = overrun;
    ev[ulsf_pkg::INT_PAR]  = charOk && rxParityBad;
    ev[ulsf_pkg::INT_FRM]  = charOk && rxStopBad;
    ev[ulsf_pkg::INT_BRK]  = brkPulse;
    ev[ulsf_pkg::INT_THRE] = holdSet;
    ev[ulsf_pkg::INT_FERR] = errPush;
    n.intStat = (s.intStat & ~w1c) | ev;
    n.irq     = |(n.intStat & n.intMask);
    n.holdIrq = n.ctrl[ulsf_pkg::CTRL_THRI] &&
                n.ls[ulsf_pkg::LS_THRE];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= RESET_ST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready     = s.awready;
  assign wready      = s.wready;
  assign bvalid      = s.bvalid;
  assign bresp       = s.bresp;
  assign arready     = s.arready;
  assign rvalid      = s.rvalid;
  assign rdata       = s.rdata;
  assign rresp       = s.rresp;
  assign rxPush      = s.rxPush;
  assign rxPushFlags = s.rxPushFlags;
  assign holdIrq     = s.holdIrq;
  assign irq         = s.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ls_read;
    arvalid && arready && (araddr == ulsf_pkg::OFS_LINE_STATUS);
  endsequence

  sequence s_char_write;
    txWrite && !txMove && !fifoMode;
  endsequence

  a_ferr_clear: assert property (
    @(posedge mclk) disable iff (reset)
    s_ls_read ##0 !errPush |=> !s.ls[ulsf_pkg::LS_FERR])
    else $error("error flag survived a status read");

  a_ferr_set: assert property (
    @(posedge mclk) disable iff (reset)
    (charOk && rxStopBad) |=> s.ls[ulsf_pkg::LS_FERR] ##1
      (s.ls[ulsf_pkg::LS_FERR] || $past(lsRead)))
    else $error("error flag missed an errored character");

  a_temt_both: assert property (
    @(posedge mclk) disable iff (reset)
    s.ls[ulsf_pkg::LS_TEMT] |-> $past(txShiftEmpty) && $past(txFifoEmpty))
    else $error("transmit empty while a character was held");

  a_temt_busy: assert property (
    @(posedge mclk) disable iff (reset)
    (!txShiftEmpty || !txFifoEmpty) |=> !s.ls[ulsf_pkg::LS_TEMT])
    else $error("transmit empty not cleared");

  a_temt_fifo: assert property (
    @(posedge mclk) disable iff (reset)
    fifoMode && txShiftEmpty && txFifoEmpty && s.ls[ulsf_pkg::LS_THRE]
      && !txWrite |=> s.ls[ulsf_pkg::LS_TEMT])
    else $error("transmit empty not set with both empty");

  a_thre_move: assert property (
    @(posedge mclk) disable iff (reset)
    !fifoMode && txMove |=> s.ls[ulsf_pkg::LS_THRE])
    else $error("holding empty not set on move");

  a_thre_write: assert property (
    @(posedge mclk) disable iff (reset)
    s_char_write |=> !s.ls[ulsf_pkg::LS_THRE] && !s.ls[ulsf_pkg::LS_TEMT])
    else $error("holding empty not cleared by write");

  a_thre_fifo: assert property (
    @(posedge mclk) disable iff (reset)
    fifoMode && $rose(txFifoEmpty) |=> s.ls[ulsf_pkg::LS_THRE] ##1
      (s.ls[ulsf_pkg::LS_THRE] || $past(txWrite)))
    else $error("holding empty not set when fifo drained");

  a_hold_irq: assert property (
    @(posedge mclk) disable iff (reset)
    holdIrq == (s.ctrl[ulsf_pkg::CTRL_THRI] && s.ls[ulsf_pkg::LS_THRE]))
    else $error("holding empty interrupt mismatch");

  a_break_flag: assert property (
    @(posedge mclk) disable iff (reset)
    !fifoMode && brkPulse |=> s.ls[ulsf_pkg::LS_BI] && rxPush &&
      rxPushFlags[ulsf_pkg::HF_BI])
    else $error("break not flagged or not loaded");

  a_frame_err: assert property (
    @(posedge mclk) disable iff (reset)
    !fifoMode && charOk && rxStopBad |=> s.ls[ulsf_pkg::LS_FE])
    else $error("framing error not flagged");

  a_head_frame: assert property (
    @(posedge mclk) disable iff (reset)
    fifoMode |=> s.ls[ulsf_pkg::LS_FE] ==
      $past(rxHeadFlags[ulsf_pkg::HF_FE] && !rxEmpty))
    else $error("framing flag not from fifo head");

  a_no_break: assert property (
    @(posedge mclk) disable iff (reset)
    !fifoMode ##0 s_ls_read ##0 !brkPulse |=> !s.ls[ulsf_pkg::LS_BI])
    else $error("break flag without break");

  a_head_parity: assert property (
    @(posedge mclk) disable iff (reset)
    fifoMode |=> s.ls[ulsf_pkg::LS_PE] ==
      $past(rxHeadFlags[ulsf_pkg::HF_PE] && !rxEmpty))
    else $error("parity flag not from fifo head");

  a_overrun: assert property (
    @(posedge mclk) disable iff (reset)
    rxCharDone && rxFifoFull && !brkPulse |=> s.ls[ulsf_pkg::LS_OE] &&
      !rxPush)
    else $error("overrun not flagged or character stored");

  a_data_ready: assert property (
    @(posedge mclk) disable iff (reset)
    ##1 s.ls[ulsf_pkg::LS_DR] == !$past(rxEmpty))
    else $error("data ready mismatch");

  a_temt_thre: assert property (
    @(posedge mclk) disable iff (reset)
    s.ls[ulsf_pkg::LS_TEMT] |-> s.ls[ulsf_pkg::LS_THRE])
    else $error("transmit empty without holding empty");
endmodule

// ===== hw/ulsf_pkg.sv
// Function
// - error flag set when stored character is errored
// - reading line status clears error flag
// - char mode: empty flag when holding, shift empty
// - empty flag low while any character held
// - fifo mode: empty flag when fifo, shift empty
// - char mode: holding empty set on move
// - char mode: holding empty cleared on write
// - fifo mode: holding empty follows fifo empty, write
// - holding empty raises interrupt when enabled
// - break flag after low for whole frame
// - one break character per break condition
// - framing flag when stop bit invalid
// - fifo mode: framing flag for head character
// - break flag stays zero without break
// - parity flag, head character in fifo mode
// - overrun flag, new character not stored
// - data ready while characters are available
package ulsf_pkg;
  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 4;
  localparam int         DATA_W          = 32;
  localparam logic [3:0] OFS_LINE_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONTROL     = 4'h4;
  localparam logic [3:0] OFS_INT_STATUS  = 4'h8;
  localparam logic [3:0] OFS_INT_MASK    = 4'hC;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int         LS_DR      = 0;
  localparam int         LS_OE      = 1;
  localparam int         LS_PE      = 2;
  localparam int         LS_FE      = 3;
  localparam int         LS_BI      = 4;
  localparam int         LS_THRE    = 5;
  localparam int         LS_TEMT    = 6;
  localparam int         LS_FERR    = 7;
  localparam logic [7:0] LS_RESET   = 8'h60;
  localparam int         CTRL_W     = 2;
  localparam int         CTRL_FIFO  = 0;
  localparam int         CTRL_THRI  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int         INT_W      = 6;
  localparam int         INT_OVR    = 0;
  localparam int         INT_PAR    = 1;
  localparam int         INT_FRM    = 2;
  localparam int         INT_BRK    = 3;
  localparam int         INT_THRE   = 4;
  localparam int         INT_FERR   = 5;
  localparam logic [5:0] INT_RESET  = 6'h00;
  localparam int         HF_W       = 3;
  localparam int         HF_PE      = 0;
  localparam int         HF_FE      = 1;
  localparam int         HF_BI      = 2;
  localparam int         BITCNT_W   = 4;
  // ----------------------------------------------------------------
  // write channel states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_COLLECT = 2'h0,
    WR_RESP    = 2'h1
  } ulsf_wr_t;
endpackage

// ===== verif/test_uart_line_status_flags.sv
module test_uart_line_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        mclk = 1'h0, reset = 1'h1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rdVal;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, wrResp, rdResp;
  logic        rxIn = 1'h1, bitTick = 1'h0, rxCharDone = 1'h0;
  logic        rxParityBad = 1'h0, rxStopBad = 1'h0, rxFifoFull = 1'h0;
  logic        rxEmpty = 1'h1, load = 1'h0, sent = 1'h0;
  logic [2:0]  rxHeadFlags = 3'h0, rxPushFlags, lastFlags = 3'h0;
  logic        rxPush, txWrite, txMove, txFifoEmpty, txShiftEmpty;
  logic        holdIrq, irq;
  int          errTotal = 0, samplesChecked = 0, pushes = 0;

  always #5 mclk = ~mclk;

  ulsf_line_status uut (.mclk, .reset, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rxIn, .bitTick, .frameBits(4'hA), .rxCharDone,
    .rxParityBad, .rxStopBad, .rxFifoFull, .rxEmpty, .rxHeadFlags,
    .rxPush, .rxPushFlags, .txWrite, .txMove, .txFifoEmpty,
    .txShiftEmpty, .holdIrq, .irq);

  ulsf_tx_model model (.mclk, .reset, .load, .sent, .txWrite, .txMove,
    .txFifoEmpty, .txShiftEmpty);

  always @(posedge mclk) begin
    if (rxPush === 1'h1) begin
      pushes++;
      lastFlags = rxPushFlags;
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task results;
    if (errTotal == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    samplesChecked++;
    if (s !== e) begin
      errTotal++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic got;
    got = 1'h0;
    @(posedge mclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        wrResp = bresp;
        got = 1'h1;
      end
    end while (!got);
  endtask

  task rchk(input logic [3:0] a, input logic [31:0] e);
    logic got;
    got = 1'h0;
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        {rdVal, rdResp} = {rdata, rresp};
        got = 1'h1;
      end
    end while (!got);
    chk(rdVal, e);
  endtask

  // one cycle command to the transmitter model, then let it settle
  task step(input logic l, input logic s);
    @(posedge mclk);
    {load, sent} <= {l, s};
    @(posedge mclk);
    {load, sent} <= 2'h0;
    repeat (4) @(posedge mclk);
  endtask

  task rxc(input logic pb, input logic sb, input logic full);
    @(posedge mclk);
    {rxCharDone, rxParityBad, rxStopBad, rxFifoFull} <= {1'h1, pb, sb, full};
    @(posedge mclk);
    {rxCharDone, rxFifoFull} <= 2'h0;
    repeat (3) @(posedge mclk);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge mclk);
    errTotal++;
    results;
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'h0;
    rchk(4'h0, 32'h60);
    wr(4'h4, 32'h2);
    step(1'h1, 1'h0);
    rchk(4'h0, 32'h20);
    chk(holdIrq, 1'h1);
    chk(irq, 1'h0);
    step(1'h1, 1'h0);
    rchk(4'h0, 32'h0);
    chk(holdIrq, 1'h0);
    wr(4'hC, 32'h10);
    rchk(4'h8, 32'h10);
    chk(irq, 1'h1);
    wr(4'h8, 32'h10);
    rchk(4'h8, 32'h0);
    chk(irq, 1'h0);
    step(1'h0, 1'h1);
    step(1'h0, 1'h1);
    rchk(4'h0, 32'h60);
    rxc(1'h0, 1'h1, 1'h0);
    chk(lastFlags, 3'h2);
    rchk(4'h0, 32'hE8);
    rchk(4'h0, 32'h60);
    rxc(1'h0, 1'h0, 1'h1);
    chk(pushes, 1);
    rchk(4'h0, 32'h62);
    rxc(1'h1, 1'h0, 1'h0);
    rchk(4'h0, 32'hE4);
    // hold the line low well past one frame: still one break char
    @(posedge mclk) rxIn <= 1'h0;
    repeat (30) begin
      @(posedge mclk) bitTick <= 1'h1;
      @(posedge mclk) bitTick <= 1'h0;
    end
    repeat (3) @(posedge mclk);
    chk(pushes, 3);
    chk(lastFlags, 3'h4);
    rchk(4'h0, 32'hF0);
    @(posedge mclk) rxIn <= 1'h1;
    rchk(4'h0, 32'h60);
    wr(4'h4, 32'h1);
    rchk(4'h4, 32'h1);
    @(posedge mclk) {rxEmpty, rxHeadFlags} <= 4'h2;
    rchk(4'h0, 32'h69);
    @(posedge mclk) rxHeadFlags <= 3'h1;
    rchk(4'h0, 32'h65);
    @(posedge mclk) rxEmpty <= 1'h1;
    rchk(4'h0, 32'h60);
    step(1'h1, 1'h0);
    rchk(4'h0, 32'h20);
    step(1'h0, 1'h1);
    rchk(4'h0, 32'h60);
    wr(4'h2, 32'h1);
    chk(wrResp, 2'h2);
    rchk(4'h2, 32'h0);
    chk(rdResp, 2'h2);
    results;
  end
endmodule

// ===== verif/ulsf_tx_model.sv
module ulsf_tx_model (
  // clock, reset and bench commands
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic load,
  input  wire logic sent,
  // transmitter side of the block
  output logic      txWrite,
  output logic      txMove,
  output logic      txFifoEmpty,
  output logic      txShiftEmpty
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // holding slot and shifter
  // ------------------------------------------------------------
  logic holdFull;
  logic shiftFull;
  // a held char moves only once the shifter is idle, as in silicon
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {holdFull, shiftFull, txWrite, txMove} <= 4'h0;
    end else begin
      txWrite   <= load;
      txMove    <= holdFull & ~shiftFull;
      holdFull  <= load | (holdFull & shiftFull);
      shiftFull <= (holdFull & ~shiftFull) | (shiftFull & ~sent);
    end
  end
  assign txFifoEmpty  = ~holdFull;
  assign txShiftEmpty = ~shiftFull;
endmodule
